// *** hw/cmsl_pkg.sv ***
// Package for the chip mode, security and low-power controller
`default_nettype none
package cmsl_pkg;
    // Operating mode codes {high, mid, low}
    typedef enum logic [2:0] {
        CMSL_MODE_SPECIAL_SINGLE = 3'h0,
        CMSL_MODE_EMUL_NARROW = 3'h1,
        CMSL_MODE_SPECIAL_TEST = 3'h2,
        CMSL_MODE_EMUL_WIDE = 3'h3,
        CMSL_MODE_NORMAL_SINGLE = 3'h4,
        CMSL_MODE_NORMAL_NARROW = 3'h5,
        CMSL_MODE_PERIPHERAL = 3'h6,
        CMSL_MODE_NORMAL_WIDE = 3'h7
    } cmsl_mode_t;

    // Low-power states
    typedef enum logic [1:0] {
        CMSL_PWR_RUN = 2'h0,
        CMSL_PWR_WAIT = 2'h1,
        CMSL_PWR_PSTOP = 2'h2,
        CMSL_PWR_STOP = 2'h3
    } cmsl_pwr_t;

    // Erase-verify sequence states
    typedef enum logic [1:0] {
        CMSL_SEC_LOCKED = 2'h0,
        CMSL_SEC_VERIFY = 2'h1,
        CMSL_SEC_VERIFIED = 2'h2,
        CMSL_SEC_OPEN = 2'h3
    } cmsl_sec_t;

    // Wishbone request carrier
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [3:0] adr;
        logic [31:0] dat;
    } cmsl_wb_req_t;

    // Register byte addresses
    localparam logic [3:0] CMSL_REG_MODE = 4'h0;
    localparam logic [3:0] CMSL_REG_MISC = 4'h4;
    localparam logic [3:0] CMSL_REG_SEC = 4'h8;
    localparam logic [3:0] CMSL_REG_PWR = 4'hC;

    // Field positions
    localparam int CMSL_MISC_VIS_BIT = 0;
    localparam int CMSL_SEC_SECURED_BIT = 0;
    localparam int CMSL_SEC_DBGACT_BIT = 1;
    localparam int CMSL_SEC_VERDONE_BIT = 2;
    localparam int CMSL_SEC_UNSECOK_BIT = 3;
    localparam int CMSL_PWR_PSTOP_BIT = 0;
    localparam int CMSL_PWR_TICK_BIT = 1;
    localparam int CMSL_PWR_WDOG_BIT = 2;
    localparam int CMSL_PWR_STATE_LSB = 4;
    localparam int CMSL_NUM_PERIPH = 8;
    localparam int CMSL_PWR_GATE_LSB = 8;

    // Reset values
    localparam cmsl_mode_t CMSL_MODE_RST = CMSL_MODE_SPECIAL_SINGLE;
    localparam logic [2:0] CMSL_PWR_CFG_RST = 3'h0;
    localparam logic [7:0] CMSL_GATE_RST = 8'h00;

    // Erase-verify sweep length in cycles
    localparam logic [7:0] CMSL_VERIFY_CYCLES = 8'h40;
endpackage : cmsl_pkg
`default_nettype wire

// *** hw/cmsl_ctrl.sv ***
// Chip mode capture, security and low-power state controller
`default_nettype none

// Function
// [R1] Mode strap pins latched into mode bits when reset releases.
// [R2] Flash visibility strap latched into the visible bit at reset release.
// [R3] Visible bit high maps internal flash; low removes it.
// [R4] Mode bits report mode; only limited writes may change them.
// [R5] Code 000 is special single-chip, flash visible, debug active at once.
// [R6] Other modes keep debug inactive until the host sends activation.
// [R7] Code 001 is emulation narrow; visible bit is inverted strap.
// [R8] Code 010 is special test wide; flash never visible. Code clears the visible bit only at reset; an unsecured MISC write can set it.
// [R9] Code 011 is emulation wide; visible bit is inverted strap.
// [R10] Code 100 is normal single-chip; flash always visible. Code sets the visible bit only at reset; an unsecured MISC write can clear it.
// [R11] Codes 101 and 111 normal narrow and wide; visible bit equals strap.
// [R12] Board must never strap code 110, peripheral mode.
// [R13] Security comes from nonvolatile flash bits, persisting across resets.
// [R14] Secured normal single-chip behaves normally but refuses debug.
// [R15] Secured expanded reset disables internal flash and refuses debug.
// [R16] Erase-verify runs in special single-chip before unsecuring allowed.
// [R17] Reset before reprogramming returns the device to secured state.
// [R18] Full stop halts clocks and oscillator; reset or interrupt wakes.
// [R19] Pseudo-stop keeps oscillator, optional tick and watchdog, others off.
// [R20] Wait stops CPU and holds its buses static; peripherals run.
// [R21] In wait each peripheral may gate its own clock.
// [R22] Security evaluated during reset before debug or flash visibility.
module cmsl_ctrl
    import cmsl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mode_strap_high_i,
    input wire logic mode_strap_mid_i,
    input wire logic mode_strap_low_i,
    input wire logic flash_visibility_strap_i,
    input wire logic nv_secured_i,
    input wire logic flash_erased_i,
    input wire logic debug_activate_i,
    input wire logic debug_request_i,
    input wire logic stop_instr_i,
    input wire logic idle_instr_i,
    input wire logic wake_interrupt_i,
    input wire logic [CMSL_NUM_PERIPH-1:0] periph_gate_req_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic flash_mapped_o,
    output logic debug_active_o,
    output logic debug_refused_o,
    output logic unsecure_allowed_o,
    output logic osc_run_o,
    output logic cpu_clk_en_o,
    output logic bus_hold_o,
    output logic tick_clk_en_o,
    output logic wdog_clk_en_o,
    output logic [CMSL_NUM_PERIPH-1:0] periph_clk_en_o
);
    cmsl_wb_req_t req;
    logic in_reset;
    cmsl_mode_t mode, next_mode;
    logic vis, next_vis;
    logic secured, next_secured;
    logic dbg_act, next_dbg_act;
    cmsl_sec_t sec, next_sec;
    logic [7:0] ver_cnt, next_ver_cnt;
    cmsl_pwr_t pwr, next_pwr;
    logic [2:0] pwr_cfg, next_pwr_cfg;
    logic [7:0] gate_en, next_gate_en;
    logic ack, next_ack;
    logic [31:0] rdat, next_rdat;
    cmsl_mode_t strap_mode;
    logic strap_vis;
    logic wr_hit;
    logic expanded;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                   adr: wb_adr_i, dat: wb_dat_i};
    assign strap_mode = cmsl_mode_t'({mode_strap_high_i, mode_strap_mid_i, mode_strap_low_i});
    assign wr_hit = req.cyc && req.stb && req.we && !ack && req.sel[0];
    assign expanded = !(mode == CMSL_MODE_SPECIAL_SINGLE || mode == CMSL_MODE_NORMAL_SINGLE);

    // Strap decode to visible bit
    always_comb begin
        case (strap_mode)
            // [R5] Special single forced
            CMSL_MODE_SPECIAL_SINGLE: strap_vis = 1'b1;
            // [R7] Emulation narrow inverted
            CMSL_MODE_EMUL_NARROW: strap_vis = !flash_visibility_strap_i;
            // [R8] Special test forced off
            CMSL_MODE_SPECIAL_TEST: strap_vis = 1'b0;
            // [R9] Emulation wide inverted
            CMSL_MODE_EMUL_WIDE: strap_vis = !flash_visibility_strap_i;
            // [R10] Normal single forced
            CMSL_MODE_NORMAL_SINGLE: strap_vis = 1'b1;
            // [R12] Peripheral code decoded only for completeness
            CMSL_MODE_PERIPHERAL: strap_vis = 1'b1;
            // [R11] Normal expanded follows strap
            default: strap_vis = flash_visibility_strap_i;
        endcase
    end

    // Mode, visibility and security
    always_comb begin
        next_mode = mode;
        next_vis = vis;
        next_secured = secured;
        next_dbg_act = dbg_act;
        next_sec = sec;
        next_ver_cnt = ver_cnt;
        if (in_reset) begin
            // [R1] Capture mode at release
            next_mode = strap_mode;
            // [R2] Capture visibility at release
            next_vis = strap_vis;
            // [R13] Nonvolatile security sampled
            next_secured = nv_secured_i;
            // [R5] Debug active in special single
            next_dbg_act = (strap_mode == CMSL_MODE_SPECIAL_SINGLE);
            // [R17] Reset relocks
            next_sec = CMSL_SEC_LOCKED;
            next_ver_cnt = 8'h00;
        end else begin
            // [R4] Limited mode switching: only codes 000 to 011 may move, and only while unsecured
            if (wr_hit && req.adr == CMSL_REG_MODE && !secured && !mode[2]
                && req.dat[2:0] != 3'h6) begin
                next_mode = cmsl_mode_t'(req.dat[2:0]);
            end
            if (wr_hit && req.adr == CMSL_REG_MISC && !secured) begin
                next_vis = req.dat[CMSL_MISC_VIS_BIT];
            end
            // [R6] Serial activation command
            if (debug_activate_i) begin
                next_dbg_act = 1'b1;
            end
            // [R16] Erase-verify sequence
            case (sec)
                CMSL_SEC_LOCKED: begin
                    if (secured && mode == CMSL_MODE_SPECIAL_SINGLE && flash_erased_i) begin
                        next_sec = CMSL_SEC_VERIFY;
                    end
                end
                CMSL_SEC_VERIFY: begin
                    if (!flash_erased_i) begin
                        next_sec = CMSL_SEC_LOCKED;
                        next_ver_cnt = 8'h00;
                    end else if (ver_cnt == CMSL_VERIFY_CYCLES - 8'h01) begin
                        next_sec = CMSL_SEC_VERIFIED;
                    end else begin
                        next_ver_cnt = ver_cnt + 8'h01;
                    end
                end
                CMSL_SEC_VERIFIED: begin
                    if (wr_hit && req.adr == CMSL_REG_SEC && !req.dat[CMSL_SEC_SECURED_BIT]) begin
                        next_sec = CMSL_SEC_OPEN;
                        next_secured = 1'b0;
                    end
                end
                CMSL_SEC_OPEN: next_sec = CMSL_SEC_OPEN;
                default: next_sec = CMSL_SEC_LOCKED;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_reset <= 1'b1;
            secured <= 1'b1;
            dbg_act <= 1'b0;
        end else begin
            in_reset <= 1'b0;
            secured <= next_secured;
            dbg_act <= next_dbg_act;
        end
        mode <= rst_i ? CMSL_MODE_RST : next_mode;
        vis <= rst_i ? 1'b0 : next_vis;
        sec <= rst_i ? CMSL_SEC_LOCKED : next_sec;
        ver_cnt <= rst_i ? 8'h00 : next_ver_cnt;
    end

    // [R22] Nothing open while in reset; security decided first
    // [R3] Visible bit maps flash; [R15] secured expanded drops it
    assign flash_mapped_o = !in_reset && vis && !(secured && expanded);
    // [R14] Secured refuses all debug
    assign debug_active_o = !in_reset && dbg_act && !secured;
    assign debug_refused_o = debug_request_i && (in_reset || secured);
    assign unsecure_allowed_o = (sec == CMSL_SEC_VERIFIED);

    // Low-power state
    always_comb begin
        next_pwr = pwr;
        next_pwr_cfg = pwr_cfg;
        next_gate_en = gate_en;
        if (wr_hit && req.adr == CMSL_REG_PWR) begin
            next_pwr_cfg = req.dat[2:0];
            next_gate_en = req.dat[CMSL_PWR_GATE_LSB +: CMSL_NUM_PERIPH];
        end
        case (pwr)
            CMSL_PWR_RUN: begin
                if (stop_instr_i) begin
                    next_pwr = pwr_cfg[CMSL_PWR_PSTOP_BIT] ? CMSL_PWR_PSTOP : CMSL_PWR_STOP;
                end else if (idle_instr_i) begin
                    next_pwr = CMSL_PWR_WAIT;
                end
            end
            // [R18] Stop, pseudo-stop and wait exit on interrupt; reset also returns to run
            CMSL_PWR_STOP, CMSL_PWR_PSTOP, CMSL_PWR_WAIT: begin
                if (wake_interrupt_i) begin
                    next_pwr = CMSL_PWR_RUN;
                end
            end
            default: next_pwr = CMSL_PWR_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        pwr <= rst_i ? CMSL_PWR_RUN : next_pwr;
        pwr_cfg <= rst_i ? CMSL_PWR_CFG_RST : next_pwr_cfg;
        gate_en <= rst_i ? CMSL_GATE_RST : next_gate_en;
    end

    // [R18] Full stop halts oscillator
    assign osc_run_o = (pwr != CMSL_PWR_STOP);
    // [R20] CPU halted and buses held outside run
    assign cpu_clk_en_o = (pwr == CMSL_PWR_RUN);
    assign bus_hold_o = (pwr != CMSL_PWR_RUN);
    // [R19] Pseudo-stop keeps selected tick and watchdog
    assign tick_clk_en_o = (pwr == CMSL_PWR_RUN) || (pwr == CMSL_PWR_WAIT)
        || (pwr == CMSL_PWR_PSTOP && pwr_cfg[CMSL_PWR_TICK_BIT]);
    assign wdog_clk_en_o = (pwr == CMSL_PWR_RUN) || (pwr == CMSL_PWR_WAIT)
        || (pwr == CMSL_PWR_PSTOP && pwr_cfg[CMSL_PWR_WDOG_BIT]);

    genvar gi;
    generate
        for (gi = 0; gi < CMSL_NUM_PERIPH; gi++) begin : g_gate
            // [R21] Per-peripheral gating in wait
            assign periph_clk_en_o[gi] = (pwr == CMSL_PWR_RUN)
                || (pwr == CMSL_PWR_WAIT && !(gate_en[gi] && periph_gate_req_i[gi]));
        end
    endgenerate

    // Wishbone answer, one cycle after the request
    always_comb begin
        next_ack = req.cyc && req.stb && !ack;
        next_rdat = 32'h0000_0000;
        case (req.adr)
            CMSL_REG_MODE: next_rdat[2:0] = mode;
            CMSL_REG_MISC: next_rdat[CMSL_MISC_VIS_BIT] = vis;
            CMSL_REG_SEC: next_rdat[3:0] = {unsecure_allowed_o, sec != CMSL_SEC_LOCKED,
                                            debug_active_o, secured};
            CMSL_REG_PWR: next_rdat[15:0] = {gate_en, 2'h0, pwr, 1'b0, pwr_cfg};
            default: next_rdat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        ack <= rst_i ? 1'b0 : next_ack;
        wb_dat_o <= rst_i ? 32'h0000_0000 : next_rdat;
    end
    assign wb_ack_o = ack;

    // Assertions
    // Capture checks look one edge past the release: the edge that releases reset
    // loads the straps and clears in_reset together, so the next edge checks them
    strap_capture_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
        $past(in_reset) && !in_reset |-> mode == $past(strap_mode))
        else $error("mode not captured from straps");
    vis_capture_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
        $past(in_reset) && !in_reset |-> vis == $past(strap_vis))
        else $error("visible bit not captured");
    map_follows_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
        !vis |-> !flash_mapped_o)
        else $error("flash mapped while not visible");
    mode_lock_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
        mode[2] && !in_reset && !rst_i |=> mode == $past(mode))
        else $error("normal mode changed while running");
    special_vis_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
        in_reset && !rst_i && strap_mode == CMSL_MODE_SPECIAL_SINGLE |=> vis && dbg_act)
        else $error("special single decode wrong");
    debug_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
        in_reset && !rst_i && strap_mode != CMSL_MODE_SPECIAL_SINGLE |=> !dbg_act)
        else $error("debug active without activation");
    narrow_vis_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
        in_reset && !rst_i && strap_mode == CMSL_MODE_EMUL_NARROW
        |=> vis != $past(flash_visibility_strap_i))
        else $error("emulation narrow not inverted");
    test_vis_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
        in_reset && !rst_i && strap_mode == CMSL_MODE_SPECIAL_TEST |=> !vis)
        else $error("special test visible");
    emul_vis_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
        in_reset && !rst_i && strap_mode == CMSL_MODE_EMUL_WIDE
        |=> vis != $past(flash_visibility_strap_i))
        else $error("emulation wide not inverted");
    single_vis_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
        in_reset && !rst_i && strap_mode == CMSL_MODE_NORMAL_SINGLE |=> vis)
        else $error("normal single not visible");
    normal_vis_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
        in_reset && !rst_i
        && (strap_mode == CMSL_MODE_NORMAL_NARROW || strap_mode == CMSL_MODE_NORMAL_WIDE)
        |=> vis == $past(flash_visibility_strap_i))
        else $error("normal expanded not following strap");
    reset_relock_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
        in_reset && !rst_i |=> secured == $past(nv_secured_i) && sec == CMSL_SEC_LOCKED)
        else $error("reset did not relock");
    secure_debug_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
        secured |-> !debug_active_o)
        else $error("debug active while secured");
    refuse_debug_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
        debug_request_i && secured |-> debug_refused_o)
        else $error("debug request not refused");
    secure_flash_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
        secured && expanded |-> !flash_mapped_o)
        else $error("flash mapped in secured expanded");
    unsecure_path_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
        !secured && $past(secured) && !$past(in_reset) |-> $past(sec) == CMSL_SEC_VERIFIED)
        else $error("unsecured without erase verify");
    verify_span_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
        sec == CMSL_SEC_LOCKED ##1 sec == CMSL_SEC_VERIFY |-> !unsecure_allowed_o [*8])
        else $error("unsecure allowed too early");
    reset_closed_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R22]
        in_reset |-> !flash_mapped_o && !debug_active_o)
        else $error("access open before security decided");
    stop_osc_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
        pwr == CMSL_PWR_RUN && stop_instr_i && !pwr_cfg[0] |=> !osc_run_o && bus_hold_o)
        else $error("stop did not halt oscillator");
    stop_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
        pwr == CMSL_PWR_STOP && !wake_interrupt_i |=> pwr == CMSL_PWR_STOP)
        else $error("stop left without wake source");
    pstop_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
        pwr == CMSL_PWR_PSTOP |-> osc_run_o && periph_clk_en_o == 8'h00)
        else $error("pseudo stop state wrong");
    wait_static_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
        pwr == CMSL_PWR_WAIT |-> !cpu_clk_en_o && bus_hold_o && osc_run_o)
        else $error("wait did not hold cpu");
    wait_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R21]
        pwr == CMSL_PWR_WAIT |-> (periph_clk_en_o | (periph_gate_req_i & gate_en)) == 8'hFF)
        else $error("peripheral gated without request");
    wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing wrong");
    unsecure_c: cover property (@(posedge clk_i) disable iff (rst_i)
        sec == CMSL_SEC_VERIFIED ##[1:20] sec == CMSL_SEC_OPEN);
    pstop_c: cover property (@(posedge clk_i) disable iff (rst_i) pwr == CMSL_PWR_PSTOP);
    wait_gate_c: cover property (@(posedge clk_i) disable iff (rst_i)
        pwr == CMSL_PWR_WAIT && periph_clk_en_o != 8'hFF);
endmodule // cmsl_ctrl
`default_nettype wire

// *** bench/cmsl_partner.sv ***
// Board strap and debug host model for the mode controller
`default_nettype none
module cmsl_partner (
    input wire logic clk_i,
    input wire logic [2:0] code_i,
    input wire logic act_i,
    output logic [2:0] strap_o,
    output logic activate_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign strap_o = (code_i == 3'h6) ? 3'h7 : code_i;
    // Host serial activation, one cycle late like a real link
    always_ff @(posedge clk_i) begin
        activate_o <= act_i;
    end
endmodule // cmsl_partner
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the chip mode, security and low-power controller
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module testbench import cmsl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, rst_i = 1'b1, vis = 1'b0, sec = 1'b0, erased = 1'b0;
    logic act = 1'b0, dreq = 1'b0, stp = 1'b0, idl = 1'b0, wake = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [2:0] code = 3'h0;
    logic [3:0] adr = 4'h0;
    logic [7:0] greq = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, seed = 32'h66A1A32A;
    logic [2:0] strap;
    logic activate, ack, mapped, dact, dref, uok, osc, cpuen, hold, tick, wdog;
    logic [7:0] pen;
    logic [63:0] note;
    logic [63:0] q[$];
    int num_errors = 0;
    int num_checks = 0;

    initial forever #20 clk_i = ~clk_i;

    cmsl_partner P (.clk_i(clk_i), .code_i(code), .act_i(act), .strap_o(strap),
        .activate_o(activate));
    cmsl_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .mode_strap_high_i(strap[2]),
        .mode_strap_mid_i(strap[1]), .mode_strap_low_i(strap[0]),
        .flash_visibility_strap_i(vis), .nv_secured_i(sec), .flash_erased_i(erased),
        .debug_activate_i(activate), .debug_request_i(dreq), .stop_instr_i(stp),
        .idle_instr_i(idl), .wake_interrupt_i(wake), .periph_gate_req_i(greq),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'hF), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .flash_mapped_o(mapped),
        .debug_active_o(dact), .debug_refused_o(dref), .unsecure_allowed_o(uok),
        .osc_run_o(osc), .cpu_clk_en_o(cpuen), .bus_hold_o(hold), .tick_clk_en_o(tick),
        .wdog_clk_en_o(wdog), .periph_clk_en_o(pen));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Read data only counts at the ack edge, so the monitor owns the compare
    always @(posedge clk_i) begin
        if (ack && !we) begin
            note = q.pop_front();
            `CHK(rdat & note[63:32], note[31:0])
        end
    end

    // For reads d is the expected word under mask m
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
        input logic [31:0] m);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= w ? d : 32'h0;
        if (!w) begin
            q.push_back({m, d});
        end
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!ack && n < 20);
        if (ack) begin
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end else begin
            num_errors++;
            $display("[ERR] %0t no ack", $time);
            finish_test();
        end
    endtask

    task automatic do_reset(input logic [2:0] m, input logic v, s, e);
        @(posedge clk_i);
        rst_i <= 1'b1;
        code <= m;
        vis <= v;
        sec <= s;
        erased <= e;
        dreq <= 1'b0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // k: 0 stop, 1 idle, 2 wake, 3 debug activation with request
    task automatic pulse(input int k);
        @(posedge clk_i);
        case (k)
            0: stp <= 1'b1;
            1: idl <= 1'b1;
            2: wake <= 1'b1;
            default: begin
                act <= 1'b1;
                dreq <= 1'b1;
            end
        endcase
        @(posedge clk_i);
        stp <= 1'b0;
        idl <= 1'b0;
        wake <= 1'b0;
        act <= 1'b0;
        repeat ((k == 3) ? 2 : 1) @(negedge clk_i);
    endtask

    initial begin
        repeat (100000) @(posedge clk_i);
        num_errors++;
        $display("[ERR] %0t run timed out", $time);
        finish_test();
    end

    initial begin
        logic ev, ex;
        int n;
        for (int i = 0; i < 8; i++) for (int v = 0; v < 2; v++) for (int s = 0; s < 2; s++) begin
            if (i == 6) continue;
            do_reset(i[2:0], v[0], s[0], 1'b0);
            case (i)
                0, 4: ev = 1'b1;
                2: ev = 1'b0;
                1, 3: ev = ~v[0];
                default: ev = v[0];
            endcase
            ex = (i != 0 && i != 4);
            @(negedge clk_i);
            `CHK(mapped, ev & ~(s[0] & ex))
            `CHK(dact, (i == 0 && s == 0))
            wb(1'b0, CMSL_REG_MODE, 32'(i), 32'h7);
            if (s == 0) wb(1'b0, CMSL_REG_MISC, {31'h0, ev}, 32'h1);
            pulse(3);
            if (!(i == 0 && s == 1)) begin
                `CHK(dact, ~s[0])
                `CHK(dref, s[0])
            end
        end
        // Mode writes: allowed from special single, not back again
        do_reset(3'h0, 1'b0, 1'b0, 1'b0);
        wb(1'b1, CMSL_REG_MODE, 32'h4, 32'h0);
        wb(1'b0, CMSL_REG_MODE, 32'h4, 32'h7);
        wb(1'b1, CMSL_REG_MODE, 32'h0, 32'h0);
        wb(1'b0, CMSL_REG_MODE, 32'h4, 32'h7);
        seed = xs(seed);
        wb(1'b1, 4'h2, seed, 32'h0);
        wb(1'b0, 4'h2, 32'h0, 32'hFFFFFFFF);
        @(posedge clk_i);
        greq <= seed[15:8];
        wb(1'b1, CMSL_REG_PWR, 32'h0000FF00, 32'h0);
        @(negedge clk_i);
        `CHK(pen, 8'hFF)
        pulse(0);
        `CHK({osc, cpuen, pen}, 10'h000)
        pulse(2);
        `CHK({osc, cpuen}, 2'h3)
        wb(1'b1, CMSL_REG_PWR, 32'h0000FF03, 32'h0);
        pulse(0);
        `CHK({osc, tick, wdog, cpuen, pen}, 12'hC00)
        pulse(2);
        pulse(1);
        `CHK({cpuen, hold, pen}, {2'h1, ~greq})
        pulse(2);
        `CHK({cpuen, hold}, 2'h2)
        // Unsecure flow: refused before the erase sweep completes
        do_reset(3'h0, 1'b0, 1'b1, 1'b1);
        wb(1'b1, CMSL_REG_SEC, 32'h0, 32'h0);
        wb(1'b0, CMSL_REG_SEC, 32'h1, 32'h1);
        n = 0;
        while (uok !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        `CHK(uok === 1'b1 && n > 40, 1'b1)
        wb(1'b1, CMSL_REG_SEC, 32'h0, 32'h0);
        wb(1'b0, CMSL_REG_SEC, 32'h0, 32'h1);
        do_reset(3'h0, 1'b0, 1'b1, 1'b1);
        wb(1'b0, CMSL_REG_SEC, 32'h1, 32'h1);
        repeat (2) @(posedge clk_i);
        finish_test();
    end
endmodule // testbench
`default_nettype wire
